// ==== adc_seq_pkg.sv ====
`default_nettype none
package adc_seq_pkg;

  // ==========================================================================
  // Register word indices (byte address is four times the index)
  localparam logic [2:0] IDX_CONTROL_ONE    = 3'h0;
  localparam logic [2:0] IDX_CONTROL_TWO    = 3'h1;
  localparam logic [2:0] IDX_CONTROL_THREE  = 3'h2;
  localparam logic [2:0] IDX_AUX_CHAN_SEL   = 3'h3;
  localparam logic [2:0] IDX_MAIN_CHAN_SEL  = 3'h4;

  localparam logic [15:0] RESET_VALUE       = 16'h0000;
  localparam logic [15:0] ONE_WRITE_MASK    = 16'h80EC;
  localparam logic [15:0] TWO_WRITE_MASK    = 16'hE73F;
  localparam logic [15:0] THREE_WRITE_MASK  = 16'h9FFF;
  localparam logic [15:0] AUX_WRITE_MASK    = 16'h0707;
  localparam logic [15:0] MAIN_WRITE_MASK   = 16'h9F9F;

  // ==========================================================================
  // Field positions
  localparam int ONE_MODULE_ON_BIT   = 15;
  localparam int ONE_TRIG_LSB        = 5;
  localparam int ONE_AUTO_START_BIT  = 2;
  localparam int ONE_SAMPLE_BIT      = 1;
  localparam int ONE_DONE_BIT        = 0;
  localparam int TWO_VREF_LSB        = 13;
  localparam int TWO_SCAN_BIT        = 10;
  localparam int TWO_CHCOUNT_LSB     = 8;
  localparam int TWO_HALF_BIT        = 7;
  localparam int TWO_SEQ_IRQ_LSB     = 2;
  localparam int TWO_SPLIT_BIT       = 1;
  localparam int TWO_ALT_BIT         = 0;
  localparam int THREE_SRC_BIT       = 15;
  localparam int THREE_AUTO_SAMPLE_TIME_LSB      = 8;
  localparam int AUX_NEG_B_LSB       = 9;
  localparam int AUX_POS_B_BIT       = 8;
  localparam int AUX_NEG_A_LSB       = 1;
  localparam int AUX_POS_A_BIT       = 0;
  localparam int MAIN_NEG_B_BIT      = 15;
  localparam int MAIN_POS_B_LSB      = 8;
  localparam int MAIN_NEG_A_BIT      = 7;
  localparam int MAIN_POS_A_LSB      = 0;

  // ==========================================================================
  // Codes
  localparam logic [2:0] TRIG_SOFTWARE = 3'h0;
  localparam logic [2:0] TRIG_EXT_PIN  = 3'h1;
  localparam logic [2:0] TRIG_TIMER    = 3'h2;
  localparam logic [2:0] TRIG_PWM      = 3'h3;
  localparam logic [2:0] TRIG_CHARGE   = 3'h6;
  localparam logic [2:0] TRIG_AUTO     = 3'h7;
  localparam logic [1:0] CHCOUNT_ONE   = 2'h0;
  localparam logic [1:0] CHCOUNT_TWO   = 2'h1;
  localparam logic [7:0] DIVIDER_MAX   = 8'h3F;
  localparam logic [3:0] BUF_SECOND    = 4'h8;
  localparam logic [1:0] AUX_NEG_SET_HI = 2'h3;
  localparam logic [3:0] AUX_POS_HI_BASE = 4'h3;
  localparam logic [3:0] AUX_NEG_HI_BASE = 4'h9;
  localparam logic [3:0] AUX_NEG_LO_BASE = 4'h6;

  typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT} seq_state_e;

  // Analog multiplexer selection toward the sample-and-hold front end
  typedef struct packed {
    logic [4:0]       ch0_pos;
    logic             ch0_neg_an1;
    logic [2:0][3:0]  aux_pos;
    logic             aux_neg_gnd;
    logic [2:0][3:0]  aux_neg;
  } mux_sel_s;

endpackage : adc_seq_pkg
`default_nettype wire

// ==== adc_sequencer_control.sv ====
// Contract
// - Manual mode: software one starts sampling
// - Source zero: software zero converts; else hardware
// - Done set at finish, cleared at start
// - Software clears done only; conversion unaffected
// - Reference always analog supply and ground
// - Scan steps channel 0 positive input
// - Channel count: one, two or four
// - Half status shows half being filled
// - Interrupt every N+1 sequences
// - Split mode alternates buffer halves per interrupt
// - Alternate mode toggles Sample A/B sets
// - RC source ignores divider
// - Auto-sample lasts field value conversion periods
// - Conversion period is divider plus one
// - Aux negative: ground, inputs 6-8 or 9-11
// - Aux positive: inputs 0-2 or 3-5
// - Channel 0 negative: input 1 or ground
// - Channel 0 positive code routing
// - Auto-start resamples after the last conversion of each sequence
// - Code 111 counter ends sampling
//
// The Avalon-MM register port and the placing of the registers were left to the implementer.
`timescale 1ns/1ns
`default_nettype none
module adc_sequencer_control #(
  parameter int CONV_PERIODS = 12
) (
  input  wire logic                   clk_sys_i,
  input  wire logic                   reset_i,
  input  wire logic [2:0]             avs_address_i,
  input  wire logic                   avs_read_i,
  input  wire logic                   avs_write_i,
  input  wire logic [31:0]            avs_writedata_i,
  input  wire logic [3:0]             avs_byteenable_i,
  output logic      [31:0]            avs_readdata_o,
  output logic                        avs_waitrequest_o,
  input  wire logic                   ext_trigger_i,
  input  wire logic                   rc_osc_i,
  input  wire logic                   timer_match_i,
  input  wire logic                   pwm_trigger_i,
  input  wire logic                   charge_trigger_i,
  input  wire logic [15:0]            scan_list_i,
  output adc_seq_pkg::mux_sel_s       mux_sel_o,
  output logic                        vref_pos_avdd_o,
  output logic                        vref_neg_avss_o,
  output logic                        sampling_o,
  output logic                        conv_start_o,
  output logic                        conv_clk_tick_o,
  output logic                        result_write_o,
  output logic      [3:0]             result_index_o,
  output logic                        irq_event_o
);
  import adc_seq_pkg::*;

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] lanes;
    lanes = {{8{be[1]}}, {8{be[0]}}} & mask;
    merge = (old & ~lanes) | (wd & lanes);
  endfunction : merge

  function automatic logic [4:0] next_scan(input logic [4:0] cur, input logic [15:0] list);
    logic [4:0] cand;
    logic       found;
    next_scan = cur;
    found = 1'b0;
    for (int i = 1; i <= 16; i++) begin
      cand = 5'((int'(cur) + i) % 16);
      if (!found && list[cand[3:0]]) begin
        next_scan = cand;
        found = 1'b1;
      end
    end
  endfunction : next_scan

  function automatic logic [3:0] aux_pos_map(input logic sel, input int k);
    aux_pos_map = sel ? 4'(AUX_POS_HI_BASE + 4'(k)) : 4'(k);
  endfunction : aux_pos_map

  function automatic logic [3:0] aux_neg_map(input logic [1:0] sel, input int k);
    aux_neg_map = (sel == AUX_NEG_SET_HI) ? 4'(AUX_NEG_HI_BASE + 4'(k))
                                          : 4'(AUX_NEG_LO_BASE + 4'(k));
  endfunction : aux_neg_map

  // ==========================================================================
  // Pin synchronisers
  logic [2:0] ext_sync_q, ext_sync_d;
  logic [2:0] rc_sync_q,  rc_sync_d;
  always_comb begin
    ext_sync_d = {ext_sync_q[1:0], ext_trigger_i};
    rc_sync_d  = {rc_sync_q[1:0], rc_osc_i};
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ext_sync_q <= 3'h0;
      rc_sync_q  <= 3'h0;
    end else begin
      ext_sync_q <= ext_sync_d;
      rc_sync_q  <= rc_sync_d;
    end
  end
  logic ext_edge, rc_edge;
  assign ext_edge = ext_sync_q[1] & ~ext_sync_q[2];
  assign rc_edge  = rc_sync_q[1] & ~rc_sync_q[2];

  // ==========================================================================
  // Avalon slave, one wait state per access
  logic        ack_q, ack_d;
  logic [31:0] rdata_q, rdata_d;
  logic        req, wr_take;
  logic [15:0] one_q, two_q, three_q, aux_q, main_q;
  logic [15:0] one_rd, two_rd;
  logic        done_q, half_q;
  seq_state_e  state_q, state_d;

  assign req               = avs_read_i | avs_write_i;
  assign avs_waitrequest_o = req & ~ack_q;
  assign wr_take           = avs_write_i & ack_q;
  assign avs_readdata_o    = rdata_q;

  always_comb begin
    one_rd = one_q & ONE_WRITE_MASK;
    one_rd[ONE_SAMPLE_BIT] = (state_q == ST_SAMPLE);
    one_rd[ONE_DONE_BIT]   = done_q;
    two_rd = two_q & TWO_WRITE_MASK;
    two_rd[TWO_HALF_BIT]   = half_q & two_q[TWO_SPLIT_BIT];
    ack_d   = req & ~ack_q;
    rdata_d = rdata_q;
    if (avs_read_i && !ack_q) begin
      case (avs_address_i)
        IDX_CONTROL_ONE:   rdata_d = {16'h0000, one_rd};
        IDX_CONTROL_TWO:   rdata_d = {16'h0000, two_rd};
        IDX_CONTROL_THREE: rdata_d = {16'h0000, three_q};
        IDX_AUX_CHAN_SEL:  rdata_d = {16'h0000, aux_q};
        IDX_MAIN_CHAN_SEL: rdata_d = {16'h0000, main_q};
        default:           rdata_d = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      ack_q   <= 1'b0;
      rdata_q <= 32'h0000_0000;
    end else begin
      ack_q   <= ack_d;
      rdata_q <= rdata_d;
    end
  end

  // ==========================================================================
  // Control registers and field views
  logic [15:0] one_d, two_d, three_d, aux_d, main_d;
  logic        wr_one;
  always_comb begin
    wr_one  = wr_take && (avs_address_i == IDX_CONTROL_ONE);
    one_d   = one_q;
    two_d   = two_q;
    three_d = three_q;
    aux_d   = aux_q;
    main_d  = main_q;
    if (wr_take) begin
      case (avs_address_i)
        IDX_CONTROL_ONE:   one_d   = merge(one_q, avs_writedata_i[15:0],
                                           avs_byteenable_i[1:0], ONE_WRITE_MASK);
        IDX_CONTROL_TWO:   two_d   = merge(two_q, avs_writedata_i[15:0],
                                           avs_byteenable_i[1:0], TWO_WRITE_MASK);
        IDX_CONTROL_THREE: three_d = merge(three_q, avs_writedata_i[15:0],
                                           avs_byteenable_i[1:0], THREE_WRITE_MASK);
        IDX_AUX_CHAN_SEL:  aux_d   = merge(aux_q, avs_writedata_i[15:0],
                                           avs_byteenable_i[1:0], AUX_WRITE_MASK);
        IDX_MAIN_CHAN_SEL: main_d  = merge(main_q, avs_writedata_i[15:0],
                                           avs_byteenable_i[1:0], MAIN_WRITE_MASK);
        default: ;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      one_q   <= RESET_VALUE;
      two_q   <= RESET_VALUE;
      three_q <= RESET_VALUE;
      aux_q   <= RESET_VALUE;
      main_q  <= RESET_VALUE;
    end else begin
      one_q   <= one_d;
      two_q   <= two_d;
      three_q <= three_d;
      aux_q   <= aux_d;
      main_q  <= main_d;
    end
  end

  logic       module_on, sample_auto_start, scan_enable, split_buffer_mode;
  logic       alternate_sample_mode, conv_clock_source;
  logic [2:0] trigger_source_sel;
  logic [1:0] channel_count_sel;
  logic [3:0] sequences_per_irq;
  logic [4:0] auto_sample_time;
  logic [7:0] conv_clock_divider, div_eff;
  logic       wr_sample_enable_bit, wr_done_bit, be_low;
  assign module_on             = one_q[ONE_MODULE_ON_BIT];
  assign trigger_source_sel    = one_q[ONE_TRIG_LSB +: 3];
  assign sample_auto_start     = one_q[ONE_AUTO_START_BIT];
  assign scan_enable           = two_q[TWO_SCAN_BIT];
  assign channel_count_sel     = two_q[TWO_CHCOUNT_LSB +: 2];
  assign sequences_per_irq     = two_q[TWO_SEQ_IRQ_LSB +: 4];
  assign split_buffer_mode     = two_q[TWO_SPLIT_BIT];
  assign alternate_sample_mode = two_q[TWO_ALT_BIT];
  assign conv_clock_source     = three_q[THREE_SRC_BIT];
  assign auto_sample_time      = three_q[THREE_AUTO_SAMPLE_TIME_LSB +: 5];
  assign conv_clock_divider    = three_q[7:0];
  assign be_low                = wr_one & avs_byteenable_i[0];
  assign wr_sample_enable_bit           = avs_writedata_i[ONE_SAMPLE_BIT];
  assign wr_done_bit           = avs_writedata_i[ONE_DONE_BIT];
  // Reserved divider codes clamp to the longest legal period
  assign div_eff = (conv_clock_divider > DIVIDER_MAX) ? DIVIDER_MAX : conv_clock_divider;
  assign vref_pos_avdd_o = 1'b1;
  assign vref_neg_avss_o = 1'b1;

  // ==========================================================================
  // Sequencer
  logic [7:0] div_cnt_q, div_cnt_d;
  logic       tick_q, tick_d;
  logic [4:0] smp_cnt_q, smp_cnt_d;
  logic [4:0] cvt_cnt_q, cvt_cnt_d;
  logic [1:0] ch_idx_q, ch_idx_d, ch_last;
  logic [3:0] seq_cnt_q, seq_cnt_d, buf_ptr_q, buf_ptr_d, res_idx_q, res_idx_d;
  logic [4:0] scan_ptr_q, scan_ptr_d;
  logic       done_d, half_d, use_b_q, use_b_d;
  logic       start_q, start_d, res_wr_q, res_wr_d, irq_q, irq_d;
  logic       trig_hit, seq_end, ch_end;
  mux_sel_s   mux_q, mux_d;

  assign ch_last = channel_count_sel[1] ? 2'h3 :
                   (channel_count_sel == CHCOUNT_TWO) ? 2'h1 : 2'h0;
  assign ch_end  = (state_q == ST_CONVERT) && tick_q
                   && (cvt_cnt_q == 5'(CONV_PERIODS - 1));
  assign seq_end = ch_end && (ch_idx_q == ch_last);

  always_comb begin
    case (trigger_source_sel)
      TRIG_EXT_PIN: trig_hit = ext_edge;
      TRIG_TIMER:   trig_hit = timer_match_i;
      TRIG_PWM:     trig_hit = pwm_trigger_i;
      TRIG_CHARGE:  trig_hit = charge_trigger_i;
      TRIG_AUTO:    trig_hit = (smp_cnt_q >= auto_sample_time);
      default:      trig_hit = 1'b0;
    endcase
  end

  always_comb begin
    div_cnt_d = div_cnt_q;
    tick_d    = 1'b0;
    if (conv_clock_source) begin
      div_cnt_d = 8'h00;
      tick_d    = rc_edge;
    end else if (div_cnt_q >= div_eff) begin
      div_cnt_d = 8'h00;
      tick_d    = 1'b1;
    end else begin
      div_cnt_d = div_cnt_q + 8'h01;
    end
    state_d    = state_q;
    smp_cnt_d  = smp_cnt_q;
    cvt_cnt_d  = cvt_cnt_q;
    ch_idx_d   = ch_idx_q;
    seq_cnt_d  = seq_cnt_q;
    buf_ptr_d  = buf_ptr_q;
    res_idx_d  = res_idx_q;
    scan_ptr_d = scan_ptr_q;
    half_d     = half_q;
    use_b_d    = use_b_q;
    start_d    = 1'b0;
    res_wr_d   = 1'b0;
    irq_d      = 1'b0;
    done_d     = done_q;
    if (be_low && !wr_done_bit) begin
      done_d = 1'b0;
    end
    case (state_q)
      ST_IDLE: begin
        if (sample_auto_start ||
            (be_low && wr_sample_enable_bit)) begin
          state_d   = ST_SAMPLE;
          smp_cnt_d = 5'h00;
        end
      end
      ST_SAMPLE: begin
        if (tick_q && smp_cnt_q != 5'h1F) begin
          smp_cnt_d = smp_cnt_q + 5'h01;
        end
        if ((trigger_source_sel == TRIG_SOFTWARE) ? (be_low && !wr_sample_enable_bit)
                                                   : trig_hit) begin
          state_d   = ST_CONVERT;
          start_d   = 1'b1;
          done_d    = 1'b0;
          cvt_cnt_d = 5'h00;
          ch_idx_d  = 2'h0;
        end
      end
      ST_CONVERT: begin
        if (tick_q) begin
          cvt_cnt_d = ch_end ? 5'h00 : cvt_cnt_q + 5'h01;
        end
        if (ch_end) begin
          res_wr_d  = 1'b1;
          res_idx_d = buf_ptr_q;
          buf_ptr_d = buf_ptr_q + 4'h1;
          ch_idx_d  = ch_idx_q + 2'h1;
        end
        if (seq_end) begin
          done_d    = 1'b1;
          use_b_d   = alternate_sample_mode ? ~use_b_q : 1'b0;
          if (scan_enable && !use_b_q) begin
            scan_ptr_d = next_scan(scan_ptr_q, scan_list_i);
          end
          seq_cnt_d = seq_cnt_q + 4'h1;
          if (seq_cnt_q == sequences_per_irq) begin
            irq_d     = 1'b1;
            seq_cnt_d = 4'h0;
            if (split_buffer_mode) begin
              half_d    = ~half_q;
              buf_ptr_d = half_q ? 4'h0 : BUF_SECOND;
            end else begin
              half_d    = 1'b0;
              buf_ptr_d = 4'h0;
            end
          end
          state_d   = sample_auto_start ? ST_SAMPLE : ST_IDLE;
          smp_cnt_d = 5'h00;
        end
      end
      default: state_d = ST_IDLE;
    endcase
    if (!module_on) begin
      state_d = ST_IDLE;
    end
  end

  // Multiplexer selection for the set in use
  always_comb begin
    logic       pos_sel;
    logic [1:0] neg_sel;
    pos_sel = use_b_q ? aux_q[AUX_POS_B_BIT] : aux_q[AUX_POS_A_BIT];
    neg_sel = use_b_q ? aux_q[AUX_NEG_B_LSB +: 2] : aux_q[AUX_NEG_A_LSB +: 2];
    mux_d = '0;
    if (use_b_q) begin
      mux_d.ch0_pos     = main_q[MAIN_POS_B_LSB +: 5];
      mux_d.ch0_neg_an1 = main_q[MAIN_NEG_B_BIT];
    end else begin
      mux_d.ch0_pos     = scan_enable ? scan_ptr_q : main_q[MAIN_POS_A_LSB +: 5];
      mux_d.ch0_neg_an1 = main_q[MAIN_NEG_A_BIT];
    end
    mux_d.aux_neg_gnd = ~neg_sel[1];
    for (int k = 0; k < 3; k++) begin
      mux_d.aux_pos[k] = aux_pos_map(pos_sel, k);
      mux_d.aux_neg[k] = neg_sel[1] ? aux_neg_map(neg_sel, k) : 4'h0;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      state_q    <= ST_IDLE;
      div_cnt_q  <= 8'h00;
      tick_q     <= 1'b0;
      smp_cnt_q  <= 5'h00;
      cvt_cnt_q  <= 5'h00;
      ch_idx_q   <= 2'h0;
      seq_cnt_q  <= 4'h0;
      buf_ptr_q  <= 4'h0;
      res_idx_q  <= 4'h0;
      scan_ptr_q <= 5'h00;
      done_q     <= 1'b0;
      half_q     <= 1'b0;
      use_b_q    <= 1'b0;
      start_q    <= 1'b0;
      res_wr_q   <= 1'b0;
      irq_q      <= 1'b0;
      mux_q      <= '0;
    end else begin
      state_q    <= state_d;
      div_cnt_q  <= div_cnt_d;
      tick_q     <= tick_d;
      smp_cnt_q  <= smp_cnt_d;
      cvt_cnt_q  <= cvt_cnt_d;
      ch_idx_q   <= ch_idx_d;
      seq_cnt_q  <= seq_cnt_d;
      buf_ptr_q  <= buf_ptr_d;
      res_idx_q  <= res_idx_d;
      scan_ptr_q <= scan_ptr_d;
      done_q     <= done_d;
      half_q     <= half_d;
      use_b_q    <= use_b_d;
      start_q    <= start_d;
      res_wr_q   <= res_wr_d;
      irq_q      <= irq_d;
      mux_q      <= mux_d;
    end
  end

  assign mux_sel_o       = mux_q;
  assign sampling_o      = (state_q == ST_SAMPLE);
  assign conv_start_o    = start_q;
  assign conv_clk_tick_o = tick_q;
  assign result_write_o  = res_wr_q;
  assign result_index_o  = res_idx_q;
  assign irq_event_o     = irq_q;

  // ==========================================================================
  // Assertions
  sequence s_convert_begins;
    state_q == ST_SAMPLE ##1 state_q == ST_CONVERT;
  endsequence
  sequence s_sequence_finishes;
    seq_end ##1 done_q;
  endsequence

  property p_done_cleared_at_start;
    @(posedge clk_sys_i) disable iff (reset_i) s_convert_begins |-> !done_q && conv_start_o;
  endproperty
  a_done_cleared_at_start: assert property (p_done_cleared_at_start)
    else $error("done not cleared at conversion start");

  property p_done_set_at_end;
    @(posedge clk_sys_i) disable iff (reset_i) seq_end && module_on |-> s_sequence_finishes;
  endproperty
  a_done_set_at_end: assert property (p_done_set_at_end)
    else $error("done not set at sequence end");

  property p_no_sw_set;
    @(posedge clk_sys_i) disable iff (reset_i)
      !done_q && !seq_end |=> !done_q;
  endproperty
  a_no_sw_set: assert property (p_no_sw_set)
    else $error("done rose without a finished sequence");

  property p_clear_keeps_state;
    @(posedge clk_sys_i) disable iff (reset_i)
      be_low && !wr_done_bit && state_q == ST_CONVERT && !seq_end && module_on
      |=> state_q == ST_CONVERT;
  endproperty
  a_clear_keeps_state: assert property (p_clear_keeps_state)
    else $error("clearing done disturbed conversion");

  property p_auto_restart;
    @(posedge clk_sys_i) disable iff (reset_i)
      seq_end && sample_auto_start && module_on |=> sampling_o;
  endproperty
  a_auto_restart: assert property (p_auto_restart)
    else $error("auto-start did not resume sampling");

  property p_hw_trigger;
    @(posedge clk_sys_i) disable iff (reset_i)
      sampling_o && trigger_source_sel != TRIG_SOFTWARE && trig_hit && module_on
      |=> state_q == ST_CONVERT ##0 conv_start_o;
  endproperty
  a_hw_trigger: assert property (p_hw_trigger)
    else $error("trigger did not start conversion");

  property p_irq_pacing;
    @(posedge clk_sys_i) disable iff (reset_i)
      irq_event_o |-> $past(seq_cnt_q) == sequences_per_irq && seq_cnt_q == 4'h0;
  endproperty
  a_irq_pacing: assert property (p_irq_pacing)
    else $error("interrupt at wrong sequence count");

  property p_split_toggle;
    @(posedge clk_sys_i) disable iff (reset_i)
      seq_end && seq_cnt_q == sequences_per_irq && split_buffer_mode
      |=> half_q != $past(half_q) && buf_ptr_q == (half_q ? BUF_SECOND : 4'h0);
  endproperty
  a_split_toggle: assert property (p_split_toggle)
    else $error("buffer half did not alternate");

  property p_restart_at_zero;
    @(posedge clk_sys_i) disable iff (reset_i)
      seq_end && seq_cnt_q == sequences_per_irq && !split_buffer_mode |=> buf_ptr_q == 4'h0;
  endproperty
  a_restart_at_zero: assert property (p_restart_at_zero)
    else $error("buffer position not reset at interrupt");

  property p_channel_count;
    @(posedge clk_sys_i) disable iff (reset_i)
      seq_end |-> ch_idx_q == (channel_count_sel[1] ? 2'h3 : 2'(channel_count_sel[0]));
  endproperty
  a_channel_count: assert property (p_channel_count)
    else $error("sequence ended on wrong channel");

endmodule : adc_sequencer_control
`default_nettype wire

// ==== analog_front_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// Front end seen across the multiplexer
module analog_front_model (
  input  wire logic clk_sys_i,
  input  wire logic reset_i,
  input  wire logic conv_start_i,
  input  wire logic conv_clk_tick_i,
  output logic      rc_osc_o,
  output int        conv_count_o,
  output int        tick_gap_o
);
  logic osc_q = 1'b0;
  int   div_q = 0;
  int   since_q = 0;
  assign rc_osc_o = osc_q;
  // Slow oscillator, six clocks a period
  always @(posedge clk_sys_i) begin
    div_q <= (div_q == 2) ? 0 : div_q + 1;
    if (div_q == 2) osc_q <= ~osc_q;
    if (reset_i) begin
      conv_count_o <= 0;
      tick_gap_o   <= 0;
      since_q      <= 0;
    end else begin
      if (conv_start_i === 1'b1) conv_count_o <= conv_count_o + 1;
      since_q <= (conv_clk_tick_i === 1'b1) ? 0 : since_q + 1;
      if (conv_clk_tick_i === 1'b1) tick_gap_o <= since_q + 1;
    end
  end
endmodule : analog_front_model
`default_nettype wire

// ==== tb_top.sv ====
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import adc_seq_pkg::*;
  logic        clk_sys_i, reset_i, avs_read_i, avs_write_i, rc_osc_i, avs_waitrequest_o;
  logic        vref_pos_avdd_o, vref_neg_avss_o, sampling_o, conv_start_o;
  logic        conv_clk_tick_o, result_write_o, irq_event_o;
  logic [2:0]  avs_address_i;
  logic [3:0]  result_index_o, be;
  logic [15:0] scan_list;
  logic [15:0] q;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  mux_sel_s    mux_sel_o;
  int          errors = 0, check_count = 0, irq_count = 0, conv_count, tick_gap;
  adc_sequencer_control #(.CONV_PERIODS(2)) uut (.clk_sys_i(clk_sys_i), .reset_i(reset_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(be),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .ext_trigger_i(1'b0), .rc_osc_i(rc_osc_i), .timer_match_i(1'b0), .pwm_trigger_i(1'b0),
    .charge_trigger_i(1'b0), .scan_list_i(scan_list), .mux_sel_o(mux_sel_o),
    .vref_pos_avdd_o(vref_pos_avdd_o), .vref_neg_avss_o(vref_neg_avss_o),
    .sampling_o(sampling_o), .conv_start_o(conv_start_o), .conv_clk_tick_o(conv_clk_tick_o),
    .result_write_o(result_write_o), .result_index_o(result_index_o),
    .irq_event_o(irq_event_o));
  analog_front_model afe (.clk_sys_i(clk_sys_i), .reset_i(reset_i), .conv_start_i(conv_start_o),
    .conv_clk_tick_i(conv_clk_tick_o), .rc_osc_o(rc_osc_i), .conv_count_o(conv_count),
    .tick_gap_o(tick_gap));
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) if (irq_event_o === 1'b1) irq_count <= irq_count + 1;
  // ==========================================
  // Tasks
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wrap_up;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  task automatic bus(input logic [2:0] a, input logic wr, input logic [15:0] d);
    int n;
    @(posedge clk_sys_i);
    avs_address_i   <= a;
    avs_write_i     <= wr;
    avs_read_i      <= ~wr;
    avs_writedata_i <= {16'h0000, d};
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      errors++;
      wrap_up;
    end
    q = avs_readdata_o[15:0];
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus
  task automatic wait_irq(input int k);
    for (int n = 0; n < 2000 && irq_count < k; n++) @(posedge clk_sys_i);
    if (irq_count < k) begin
      errors++;
      wrap_up;
    end
  endtask : wait_irq
  // ==========================================
  // Tests
  initial begin
    reset_i = 1'b1;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_address_i = 3'h0;
    avs_writedata_i = 32'h0000_0000;
    be = 4'h3;
    scan_list = 16'h0030;
    repeat (3) @(posedge clk_sys_i);
    reset_i <= 1'b0;
    for (int i = 0; i < 8; i++) begin
      bus(i[2:0], 1'b0, 16'h0000);
      chk(q, 16'h0000);
    end
    $display("test reset done");
    bus(IDX_MAIN_CHAN_SEL, 1'b1, 16'h008D);
    bus(IDX_AUX_CHAN_SEL, 1'b1, 16'h0407);
    repeat (2) @(negedge clk_sys_i);
    chk(mux_sel_o.ch0_pos, 5'h0D);
    chk(mux_sel_o.ch0_neg_an1, 1'b1);
    chk(mux_sel_o.aux_pos[0], 4'h3);
    chk(mux_sel_o.aux_neg[0], 4'h9);
    chk({vref_pos_avdd_o, vref_neg_avss_o}, 2'b11);
    $display("test mux done");
    bus(IDX_CONTROL_TWO, 1'b1, 16'h0404);
    for (int s = 0; s < 2; s++) begin
      bus(IDX_CONTROL_ONE, 1'b1, 16'h8000);
      bus(IDX_CONTROL_ONE, 1'b0, 16'h0000);
      chk(q, 16'h8000);
      bus(IDX_CONTROL_ONE, 1'b1, 16'h8002);
      bus(IDX_CONTROL_ONE, 1'b0, 16'h0000);
      chk(q, 16'h8002);
      chk(sampling_o, 1'b1);
      bus(IDX_CONTROL_ONE, 1'b1, 16'h8000);
      for (int n = 0; n < 60 && q[0] !== 1'b1; n++) bus(IDX_CONTROL_ONE, 1'b0, 16'h0000);
      chk(q, 16'h8001);
    end
    chk(conv_count, 2);
    chk(irq_count, 1);
    chk(mux_sel_o.ch0_pos, 5'h05);
    chk(result_index_o, 4'h1);
    be <= 4'h2;
    bus(IDX_CONTROL_ONE, 1'b1, 16'h8000);
    be <= 4'h3;
    bus(IDX_CONTROL_ONE, 1'b0, 16'h0000);
    chk(q, 16'h8001);
    $display("test manual done");
    bus(IDX_CONTROL_THREE, 1'b1, 16'h0303);
    bus(IDX_CONTROL_ONE, 1'b1, 16'h80E4);
    wait_irq(3);
    chk(irq_count, 3);
    chk(tick_gap, 4);
    bus(IDX_CONTROL_THREE, 1'b1, 16'h8303);
    wait_irq(5);
    chk(tick_gap, 6);
    bus(IDX_CONTROL_ONE, 1'b1, 16'h0000);
    $display("test auto done");
    wrap_up;
  end
endmodule : tb_top
`default_nettype wire
